// >>> src/lccr_pkg.sv
package lccr_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  localparam int IDX_W = 6;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_L1_IDLE_RATE = 6'h23;
  localparam logic [IDX_W-1:0] IDX_B1_EQ = 6'h24;
  localparam logic [IDX_W-1:0] IDX_L1_SWING = 6'h25;
  localparam logic [IDX_W-1:0] IDX_L1_DEEMPH = 6'h26;
  localparam logic [IDX_W-1:0] IDX_B1_THRESH = 6'h27;
  localparam logic [IDX_W-1:0] IDX_A0_IDLE_RATE = 6'h2b;

  localparam logic [REG_W-1:0] RST_IDLE_RATE = 8'h00;
  localparam logic [REG_W-1:0] RST_EQ = 8'h20;
  localparam logic [REG_W-1:0] RST_SWING = 8'h03;
  localparam logic [REG_W-1:0] RST_DEEMPH = 8'h03;
  localparam logic [REG_W-1:0] RST_THRESH = 8'h00;

  localparam int IDLE_AUTO_BIT = 5;
  localparam int IDLE_SEL_BIT = 4;
  localparam int RATE_AUTO_BIT = 1;
  localparam int RATE_SEL_BIT = 0;
  localparam int EQ_EN_BIT = 5;
  localparam int GAIN_LO = 3;
  localparam int BOOST_LO = 0;
  localparam int DEM_TYPE_BIT = 7;
  localparam int THR_DEASSERT_LO = 2;
  localparam int THR_ASSERT_LO = 0;

  typedef struct packed {
    logic idle_auto;
    logic mute;
    logic signal_detect_en;
    logic rate_auto;
    logic rate_high;
  } lccr_idle_rate_t;

  typedef struct packed {
    logic enable;
    logic bypass;
    logic [1:0] gain_stage_field;
    logic [2:0] boost_level_field;
    logic known;
    logic [8:0] boost_db10;
  } lccr_eq_t;

  typedef struct packed {
    logic [6:0] code;
    logic known;
    logic [10:0] amp_mv;
  } lccr_swing_t;

  typedef struct packed {
    logic enhanced;
    logic [6:0] level;
    logic known;
    logic [6:0] atten_db10;
  } lccr_deemph_t;

  typedef struct packed {
    logic [7:0] deassert_mv;
    logic [7:0] assert_mv;
  } lccr_thresh_t;

endpackage

// >>> src/lccr_regs.sv
// Implementation choice: the APB slave port.
`timescale 1ns/100ps

// Function
// - An idle/rate register with its idle-auto bit 5 set detects idle itself, else bit 4 governs.
// - With idle-auto off, bit 4 low keeps the output on without signal detect, high mutes it.
// - With rate-auto bit 1 set the rate is detected, else bit 0 selects the rate range.
// - Rate select low means 2.5 to 3.2 Gbps and high means 5.0 to 6.4 Gbps.
// - The 6-bit equalizer code is enable at 5, gain stage at 4:3 and boost level at 2:0.
// - Equalizer code 20h is bypass and the reset value, and 2Ah gives 5 dB at 3 GHz.
// - Codes 30h, 32h, 39h, 35h, 37h, 3Bh, 3Dh give 9, 11.7, 14.6, 18.4, 20, 21.2, 28.4 dB.
// - Swing codes 03h, 07h, 0Fh, 1Fh give 600, 800, 1000 and 1200 mV, 03h by default.
// - De-emphasis bit 7 picks compatibility or enhanced type and bits 6:0 hold the level.
// - De-emphasis codes 01h, E8h, 88h, 90h, A0h give 0, -3.5, -6, -9, -12 dB; reset is 03h.
// - The idle threshold takes its de-assert code from bits 3:2 and assert code from 1:0.
module lccr_regs (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [lccr_pkg::ADDR_W-1:0] PADDR,
  input wire logic [lccr_pkg::DATA_W-1:0] PWDATA,
  output logic [lccr_pkg::DATA_W-1:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output lccr_pkg::lccr_idle_rate_t L1_IDLE_RATE,
  output lccr_pkg::lccr_idle_rate_t A0_IDLE_RATE,
  output lccr_pkg::lccr_eq_t B1_EQ,
  output lccr_pkg::lccr_swing_t L1_SWING,
  output lccr_pkg::lccr_deemph_t L1_DEEMPH,
  output lccr_pkg::lccr_thresh_t B1_THRESH
);
  import lccr_pkg::*;

  typedef struct packed {
    logic [REG_W-1:0] l1_idle_rate;
    logic [REG_W-1:0] b1_eq;
    logic [REG_W-1:0] l1_swing;
    logic [REG_W-1:0] l1_deemph;
    logic [REG_W-1:0] b1_thresh;
    logic [REG_W-1:0] a0_idle_rate;
    logic pready;
    logic pslverr;
    logic [DATA_W-1:0] prdata;
    lccr_idle_rate_t l1_ir;
    lccr_idle_rate_t a0_ir;
    lccr_eq_t eq;
    lccr_swing_t swing;
    lccr_deemph_t deemph;
    lccr_thresh_t thresh;
  } lccr_state_t;

  function automatic lccr_idle_rate_t decode_idle_rate(
    input logic [REG_W-1:0] r
  );
    lccr_idle_rate_t d;
    // Idle mode choice
    // auto versus forced
    d.idle_auto = r[IDLE_AUTO_BIT];
    d.mute = !r[IDLE_AUTO_BIT] && r[IDLE_SEL_BIT];
    d.signal_detect_en = r[IDLE_AUTO_BIT];
    d.rate_auto = r[RATE_AUTO_BIT];
    d.rate_high = !r[RATE_AUTO_BIT] && r[RATE_SEL_BIT];
    return d;
  endfunction

  function automatic lccr_eq_t decode_eq(
    input logic [REG_W-1:0] r
  );
    lccr_eq_t d;
    d.enable = r[EQ_EN_BIT];
    d.gain_stage_field = r[GAIN_LO+1:GAIN_LO];
    d.boost_level_field = r[BOOST_LO+2:BOOST_LO];
    d.bypass = 1'b0;
    d.known = 1'b1;
    // Boost in tenths of a dB at 3 GHz
    case (r[5:0])
      6'h20: begin
        d.bypass = 1'b1;
        d.boost_db10 = 9'h000;
      end
      6'h2a: d.boost_db10 = 9'd50;
      6'h30: d.boost_db10 = 9'd90;
      6'h32: d.boost_db10 = 9'd117;
      6'h39: d.boost_db10 = 9'd146;
      6'h35: d.boost_db10 = 9'd184;
      6'h37: d.boost_db10 = 9'd200;
      6'h3b: d.boost_db10 = 9'd212;
      6'h3d: d.boost_db10 = 9'd284;
      default: begin
        // Untabled codes still reach the analog side as raw fields
        d.known = 1'b0;
        d.boost_db10 = 9'h000;
      end
    endcase
    return d;
  endfunction

  function automatic lccr_swing_t decode_swing(
    input logic [REG_W-1:0] r
  );
    lccr_swing_t d;
    d.code = r[6:0];
    d.known = 1'b1;
    case (r[6:0])
      7'h03: d.amp_mv = 11'd600;
      7'h07: d.amp_mv = 11'd800;
      7'h0f: d.amp_mv = 11'd1000;
      7'h1f: d.amp_mv = 11'd1200;
      default: begin
        d.known = 1'b0;
        d.amp_mv = 11'h000;
      end
    endcase
    return d;
  endfunction

  function automatic lccr_deemph_t decode_deemph(
    input logic [REG_W-1:0] r
  );
    lccr_deemph_t d;
    d.enhanced = r[DEM_TYPE_BIT];
    d.level = r[6:0];
    d.known = 1'b1;
    case (r)
      8'h01: d.atten_db10 = 7'd0;
      8'he8: d.atten_db10 = 7'd35;
      8'h88: d.atten_db10 = 7'd60;
      8'h90: d.atten_db10 = 7'd90;
      8'ha0: d.atten_db10 = 7'd120;
      default: begin
        // Reset code 03h is not tabled and reads as unknown
        d.known = 1'b0;
        d.atten_db10 = 7'h00;
      end
    endcase
    return d;
  endfunction

  function automatic logic [7:0] deassert_mv(
    input logic [1:0] c
  );
    logic [7:0] v;
    case (c)
      2'h0: v = 8'd110;
      2'h1: v = 8'd150;
      2'h2: v = 8'd170;
      default: v = 8'd190;
    endcase
    return v;
  endfunction

  function automatic logic [7:0] assert_mv(
    input logic [1:0] c
  );
    logic [7:0] v;
    case (c)
      2'h0: v = 8'd70;
      2'h1: v = 8'd110;
      2'h2: v = 8'd130;
      default: v = 8'd150;
    endcase
    return v;
  endfunction

  function automatic lccr_state_t decode_all(
    input lccr_state_t s
  );
    lccr_state_t d;
    d = s;
    d.l1_ir = decode_idle_rate(s.l1_idle_rate);
    d.a0_ir = decode_idle_rate(s.a0_idle_rate);
    d.eq = decode_eq(s.b1_eq);
    d.swing = decode_swing(s.l1_swing);
    d.deemph = decode_deemph(s.l1_deemph);
    d.thresh.deassert_mv = deassert_mv(s.b1_thresh[THR_DEASSERT_LO+1:THR_DEASSERT_LO]);
    d.thresh.assert_mv = assert_mv(s.b1_thresh[THR_ASSERT_LO+1:THR_ASSERT_LO]);
    return d;
  endfunction

  function automatic lccr_state_t reset_state();
    lccr_state_t d;
    d = '0;
    d.l1_idle_rate = RST_IDLE_RATE;
    d.b1_eq = RST_EQ;
    d.l1_swing = RST_SWING;
    d.l1_deemph = RST_DEEMPH;
    d.b1_thresh = RST_THRESH;
    d.a0_idle_rate = RST_IDLE_RATE;
    return decode_all(d);
  endfunction

  // One-hot word select; misaligned or unmapped addresses select nothing
  function automatic logic [5:0] decode_sel(
    input logic [ADDR_W-1:0] a
  );
    logic [5:0] s;
    logic aligned;
    s = 6'h00;
    aligned = a[1:0] == 2'h0;
    if (aligned) begin
      case (a[IDX_W+1:2])
        IDX_L1_IDLE_RATE: s = 6'h01;
        IDX_B1_EQ: s = 6'h02;
        IDX_L1_SWING: s = 6'h04;
        IDX_L1_DEEMPH: s = 6'h08;
        IDX_B1_THRESH: s = 6'h10;
        IDX_A0_IDLE_RATE: s = 6'h20;
        default: s = 6'h00;
      endcase
    end
    return s;
  endfunction

  // The select is one-hot, so at most one word reaches the read bus
  function automatic logic [REG_W-1:0] read_sel(
    input lccr_state_t st,
    input logic [5:0] s
  );
    logic [REG_W-1:0] v;
    v = '0;
    if (s[0]) begin
      v = st.l1_idle_rate;
    end
    if (s[1]) begin
      v = st.b1_eq;
    end
    if (s[2]) begin
      v = st.l1_swing;
    end
    if (s[3]) begin
      v = st.l1_deemph;
    end
    if (s[4]) begin
      v = st.b1_thresh;
    end
    if (s[5]) begin
      v = st.a0_idle_rate;
    end
    return v;
  endfunction

  // Reserved bits are kept as written; keeping them zero is up to software
  function automatic lccr_state_t write_sel(
    input lccr_state_t st,
    input logic [5:0] s,
    input logic [REG_W-1:0] v
  );
    lccr_state_t d;
    d = st;
    if (s[0]) begin
      d.l1_idle_rate = v;
    end
    if (s[1]) begin
      d.b1_eq = v;
    end
    if (s[2]) begin
      d.l1_swing = v;
    end
    if (s[3]) begin
      d.l1_deemph = v;
    end
    if (s[4]) begin
      d.b1_thresh = v;
    end
    if (s[5]) begin
      d.a0_idle_rate = v;
    end
    return d;
  endfunction

  localparam lccr_state_t STATE_RST = reset_state();

  lccr_state_t state_reg;
  lccr_state_t state_next;
  logic [5:0] sel;
  logic hit;
  logic [REG_W-1:0] rd_val;
  logic access;

  assign sel = decode_sel(PADDR);
  // A refused access still gets its wait state, so timing never depends on the address
  assign hit = |sel;
  assign rd_val = read_sel(state_reg, sel);
  assign access = PSEL && PENABLE;

  always_comb begin
    state_next = state_reg;
    state_next.pready = 1'b0;
    // One wait state so read data and the error come from flip-flops
    if (access && !state_reg.pready) begin
      state_next.pready = 1'b1;
      state_next.pslverr = !hit;
      state_next.prdata = (hit && !PWRITE) ? {24'h000000, rd_val} : 32'h00000000;
    end
    // Write lands on the edge that completes the transfer
    if (access && state_reg.pready && PWRITE) begin
      state_next = write_sel(state_next, sel, PWDATA[REG_W-1:0]);
    end
    // A completed access clears the bus outputs so they stand one cycle
    if (access && state_reg.pready) begin
      state_next.prdata = 32'h00000000;
      state_next.pslverr = 1'b0;
    end
    // Decoded controls follow the stored fields with no extra lag
    state_next = decode_all(state_next);
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_reg <= STATE_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  assign PRDATA = state_reg.prdata;
  assign PREADY = state_reg.pready;
  assign PSLVERR = state_reg.pslverr;
  assign L1_IDLE_RATE = state_reg.l1_ir;
  assign A0_IDLE_RATE = state_reg.a0_ir;
  assign B1_EQ = state_reg.eq;
  assign L1_SWING = state_reg.swing;
  assign L1_DEEMPH = state_reg.deemph;
  assign B1_THRESH = state_reg.thresh;

endmodule

// >>> verification/lccr_regs_sva.sv
`timescale 1ns/100ps
module lccr_sva (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [lccr_pkg::ADDR_W-1:0] PADDR,
  input wire logic [lccr_pkg::DATA_W-1:0] PWDATA,
  input wire logic [lccr_pkg::DATA_W-1:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire lccr_pkg::lccr_idle_rate_t L1_IDLE_RATE,
  input wire lccr_pkg::lccr_idle_rate_t A0_IDLE_RATE,
  input wire lccr_pkg::lccr_eq_t B1_EQ,
  input wire lccr_pkg::lccr_swing_t L1_SWING,
  input wire lccr_pkg::lccr_deemph_t L1_DEEMPH,
  input wire lccr_pkg::lccr_thresh_t B1_THRESH
);
  import lccr_pkg::*;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  a_one_wait: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("ready late");
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready held");
  a_bad_addr: assert property (PREADY && PADDR[1:0] != 2'h0 |-> PSLVERR && PRDATA == 32'h0)
    else $error("misaligned not refused");
  a_read_back: assert property (PREADY && !PWRITE && PADDR == 8'h94 |-> PRDATA[6:0] == L1_SWING.code)
    else $error("swing readback");
  // Decoded level must follow the stored byte on the very next edge
  a_deemph_store: assert property (PREADY && PWRITE && PADDR == 8'h98
    |=> {L1_DEEMPH.enhanced, L1_DEEMPH.level} == $past(PWDATA[7:0])) else $error("deemph store");
  a_idle_force: assert property (L1_IDLE_RATE.mute |-> !L1_IDLE_RATE.idle_auto)
    else $error("mute under auto");
  a_sd_auto: assert property (A0_IDLE_RATE.signal_detect_en == A0_IDLE_RATE.idle_auto)
    else $error("signal detect");
  a_rate_force: assert property (L1_IDLE_RATE.rate_high |-> !L1_IDLE_RATE.rate_auto)
    else $error("rate under auto");
  a_eq_bypass: assert property (B1_EQ.bypass |-> B1_EQ.enable && B1_EQ.boost_db10 == 9'h000)
    else $error("bypass boost");
  a_swing_dflt: assert property (L1_SWING.code == 7'h03 |-> L1_SWING.amp_mv == 11'h258)
    else $error("swing 600");
endmodule

bind lccr_regs lccr_sva i_lccr_sva (.CLK(CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .L1_IDLE_RATE(L1_IDLE_RATE), .A0_IDLE_RATE(A0_IDLE_RATE), .B1_EQ(B1_EQ),
  .L1_SWING(L1_SWING), .L1_DEEMPH(L1_DEEMPH), .B1_THRESH(B1_THRESH));

// >>> verification/tb_lccr_regs.sv
`timescale 1ns/100ps
module tb_lccr_regs;
  import lccr_pkg::*;
  logic CLK = 0, RSTN = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA, r;
  logic PREADY, PSLVERR, e;
  lccr_idle_rate_t L1_IDLE_RATE, A0_IDLE_RATE;
  lccr_eq_t B1_EQ;
  lccr_swing_t L1_SWING;
  lccr_deemph_t L1_DEEMPH;
  lccr_thresh_t B1_THRESH;
  int err_total = 0, comparisons = 0;
  logic [7:0] adr[6] = '{8'h8c, 8'h90, 8'h94, 8'h98, 8'h9c, 8'hac};
  logic [7:0] rst_v[6] = '{8'h00, 8'h20, 8'h03, 8'h03, 8'h00, 8'h00};
  logic [7:0] eq_c[9] = '{8'h20, 8'h2a, 8'h30, 8'h32, 8'h39, 8'h35, 8'h37, 8'h3b, 8'h3d};
  // Boost in tenths of a dB
  logic [8:0] eq_db[9] = '{9'h0, 9'h32, 9'h5a, 9'h75, 9'h92, 9'hb8, 9'hc8, 9'hd4, 9'h11c};
  logic [7:0] sw_c[4] = '{8'h03, 8'h07, 8'h0f, 8'h1f};
  logic [10:0] sw_mv[4] = '{11'h258, 11'h320, 11'h3e8, 11'h4b0};
  logic [7:0] dm_c[5] = '{8'h01, 8'he8, 8'h88, 8'h90, 8'ha0};
  logic [6:0] dm_db[5] = '{7'h00, 7'h23, 7'h3c, 7'h5a, 7'h78};
  logic [7:0] thr_d[4] = '{8'h6e, 8'h96, 8'haa, 8'hbe};
  logic [7:0] thr_a[4] = '{8'h46, 8'h6e, 8'h82, 8'h96};

  lccr_regs i_lccr_regs (.CLK(CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .L1_IDLE_RATE(L1_IDLE_RATE), .A0_IDLE_RATE(A0_IDLE_RATE), .B1_EQ(B1_EQ),
    .L1_SWING(L1_SWING), .L1_DEEMPH(L1_DEEMPH), .B1_THRESH(B1_THRESH));

  always #2.5 CLK = ~CLK;

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    comparisons++;
    if (g !== x) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, g, x);
    end
  endtask

  // One idle edge after each transfer so no strobe is driven twice in a step
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= {24'h0, d};
    @(posedge CLK);
    PENABLE <= 1'b1;
    // Wait for the answer as long as it takes; only the watchdog ends a hang
    do begin
      @(posedge CLK);
    end while (PREADY !== 1'b1);
    r = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
    chk(e, 1'b0);
  endtask

  function automatic logic [4:0] ir(input logic [7:0] v);
    return {v[5], ~v[5] & v[4], v[5], v[1], ~v[1] & v[0]};
  endfunction

  task automatic t_reset;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, adr[i], 8'h00);
      chk(r, rst_v[i]);
      chk(e, 1'b0);
    end
    chk(B1_EQ.bypass, 1'b1);
    chk(L1_SWING.amp_mv, 11'h258);
    chk(B1_THRESH, 16'h6e46);
    chk(L1_DEEMPH, {8'h03, 1'b0, 7'h00});
    chk(A0_IDLE_RATE, 5'h00);
  endtask

  task automatic t_idle;
    logic [7:0] v;
    for (int i = 0; i < 16; i++) begin
      v = {2'b00, i[3:2], 2'b00, i[1:0]};
      wr(8'h8c, v);
      wr(8'hac, v ^ 8'h33);
      chk(L1_IDLE_RATE, ir(v));
      chk(A0_IDLE_RATE, ir(v ^ 8'h33));
      apb(1'b0, 8'hac, 8'h00);
      chk(r, v ^ 8'h33);
    end
  endtask

  task automatic t_codes;
    for (int i = 0; i < 9; i++) begin
      wr(8'h90, eq_c[i]);
      chk(B1_EQ, {eq_c[i][5], eq_c[i] == 8'h20, eq_c[i][4:0], 1'b1, eq_db[i]});
    end
    for (int i = 0; i < 5; i++) begin
      wr(8'h98, dm_c[i]);
      chk(L1_DEEMPH, {dm_c[i], 1'b1, dm_db[i]});
    end
    for (int i = 0; i < 4; i++) begin
      // reserved swing code 3Fh is never written
      wr(8'h94, sw_c[i]);
      apb(1'b0, 8'h94, 8'h00);
      chk(r, sw_c[i]);
      chk(L1_SWING, {sw_c[i][6:0], 1'b1, sw_mv[i]});
    end
    for (int i = 0; i < 16; i++) begin
      wr(8'h9c, i[7:0]);
      chk(B1_THRESH, {thr_d[i[3:2]], thr_a[i[1:0]]});
    end
  endtask

  task automatic t_err;
    apb(1'b0, 8'h00, 8'h00);
    chk(r, 32'h0);
    chk(e, 1'b1);
    apb(1'b1, 8'h95, 8'h07);
    chk(e, 1'b1);
    apb(1'b0, 8'h94, 8'h00);
    chk(r, 32'h1f);
  endtask

  task automatic give_verdict;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge CLK);
    RSTN <= 1'b1;
    @(posedge CLK);
    t_reset();
    t_idle();
    t_codes();
    t_err();
    RSTN <= 1'b0;
    repeat (2) @(posedge CLK);
    RSTN <= 1'b1;
    @(posedge CLK);
    t_reset();
    give_verdict();
  end

  initial begin
    repeat (5000) @(posedge CLK);
    err_total++;
    give_verdict();
  end
endmodule
